// ==== pattern_output_pkg.sv ====
// Constants shared by the pattern output control block and its group slice.
// Assumes a 32-bit APB master; register indexes map to byte address index * 4.
package pattern_output_pkg;

  // Bus geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [1:0] WORD_PAD = 2'h0;

  // Register indexes as printed; byte address is the index times four
  localparam logic [19:0] IDX_MODE = 20'hFFFA0;
  localparam logic [19:0] IDX_TRIG_SEL = 20'hFFFA1;
  localparam logic [19:0] IDX_EN_HIGH = 20'hFFFA2;
  localparam logic [19:0] IDX_EN_LOW = 20'hFFFA3;
  localparam logic [19:0] IDX_ND_HIGH_LO = 20'hFFFA4;
  localparam logic [19:0] IDX_ND_LOW_LO = 20'hFFFA5;
  localparam logic [19:0] IDX_ND_HIGH_HI = 20'hFFFA6;
  localparam logic [19:0] IDX_ND_LOW_HI = 20'hFFFA7;

  // Reset values and read-as-one patterns
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] MODE_RSVD = 4'hF;
  localparam logic [7:0] TRIG_SEL_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [15:0] ND_RST = 16'h0000;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] NIB_ONES = 4'hF;

  // Trigger select codes; any code with the upper bit set picks channel 2
  localparam logic [1:0] SEL_CH0 = 2'h0;
  localparam logic [1:0] SEL_CH1 = 2'h1;
  localparam logic [1:0] CH_IDX2 = 2'h2;

  // Structure
  localparam int GROUPS = 4;
  localparam int GROUP_W = 4;
  localparam int CHANNELS = 3;
  localparam int SEL_W = 2;

  // Timer channel picked by a select code
  function automatic logic [1:0] chan_of(input logic [1:0] sel);
    logic [1:0] ch;
    ch = CH_IDX2;
    if (sel == SEL_CH0)
    begin
      ch = SEL_CH0;
    end
    else if (sel == SEL_CH1)
    begin
      ch = SEL_CH1;
    end
    return ch;
  endfunction

endpackage

// ==== pattern_group.sv ====
// One four-line output group: trigger selection and the output latch.
// Assumes compare match inputs are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
module pattern_group
  import pattern_output_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [SEL_W-1:0] sel,
  input wire logic nonoverlap,
  input wire logic [GROUP_W-1:0] line_en,
  input wire logic [GROUP_W-1:0] next_data,
  // Timer compare matches
  input wire logic [CHANNELS-1:0] cm_a,
  input wire logic [CHANNELS-1:0] cm_b,
  // Pattern output lines
  output logic [GROUP_W-1:0] lines_q
);

  logic trig_a;
  logic trig_b;
  logic [1:0] ch;

  // Channel mux, codes 10 and 11 both reach channel 2
  assign ch = chan_of(sel);
  assign trig_a = cm_a[ch];
  assign trig_b = cm_b[ch];

  // Enabled lines update on the selected match; disabled lines hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lines_q <= '0;
    end
    else if (trig_a)
    begin
      lines_q <= (lines_q & ~line_en) | (next_data & line_en);
    end
    else if (nonoverlap && trig_b)
    begin
      // Changing lines drop to 0 first so a falling line and a rising line are never high together
      lines_q <= lines_q & ~(line_en & (lines_q ^ next_data));
    end
  end

  // Disabled lines never move
  a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (((lines_q ^ $past(lines_q)) & ~$past(line_en)) == '0))
    else $error("disabled line changed");

  // Match A copies enabled next data in one cycle
  a_match_a_load: assert property (@(posedge pclk) disable iff (!presetn)
    trig_a |=> ((lines_q & $past(line_en)) == ($past(next_data) & $past(line_en))))
    else $error("match A did not load next data");

  // Code 11 behaves as channel 2
  a_code3_chan2: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == 2'h3) |-> (trig_a == cm_a[2] && trig_b == cm_b[2]))
    else $error("code 11 not mapped to channel 2");

  // Normal mode ignores match B
  a_normal_ignores_b: assert property (@(posedge pclk) disable iff (!presetn)
    (!nonoverlap && !trig_a) |=> $stable(lines_q))
    else $error("normal mode output moved without match A");

  // Non-overlap match B only clears lines
  a_nov_b_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (nonoverlap && trig_b && !trig_a) |=> ((lines_q & ~$past(lines_q)) == '0))
    else $error("non-overlap match B raised a line");

endmodule

// ==== pattern_output_control.sv ====
// APB register file and output steering for the sixteen-line pattern unit.
// Assumes an APB master on pclk and compare match pulses from a 16-bit timer.
// Behaviour
// - Per-group non-overlap bit: 0 updates on match A, 1 uses A and B.
// - Select bits 1:0 pick group 0 trigger: 00 ch0, 01 ch1, 10 ch2.
// - Select bits 3:2 pick group 1 trigger: 00 ch0, 01 ch1, 10 ch2.
// - Select bits 5:4 pick group 2 trigger: 00 ch0, 01 ch1, 11 ch2.
// - Select bits 7:6 pick group 3 trigger: 00 ch0, 01 ch1, 1x ch2.
// - Upper enable 1 lets next data reach port B pin on its trigger.
// - Upper enable 0 stops transfer to that port B pin.
// - Lower enable 1 lets next data reach port A pin on its trigger.
// - Lower enable 0 stops transfer to that port A pin.
// - All sixteen enable bits are read/write and reset to zero.
// - Groups 2 and 3 sharing a trigger: byte at lower address, upper reads ones.
// - Different triggers: group 3 upper nibble low address, group 2 low nibble upper.
`timescale 1ns/1ps
module pattern_output_control
  import pattern_output_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer compare matches, one bit per channel
  input wire logic [CHANNELS-1:0] cm_a,
  input wire logic [CHANNELS-1:0] cm_b,
  // Pattern output pins and their enables
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_oe
);

  logic [3:0] pattern_output_mode_q;
  logic [7:0] pattern_trigger_select_q;
  logic [7:0] next_data_enable_high_q;
  logic [7:0] next_data_enable_low_q;
  logic [15:0] next_data_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rd_d;
  logic pready_q;
  logic pslverr_q;
  logic hit_d;
  logic setup;
  logic wr_en;
  logic shared_high;
  logic shared_low;
  logic [15:0] lines;
  logic [15:0] line_en;

  // Address decode helper
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [19:0] idx);
    return a == {idx, WORD_PAD};
  endfunction

  assign setup = psel && !penable;
  // Write lands on the completing access edge only
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  // Same trigger when both groups resolve to one channel
  assign shared_high = chan_of(pattern_trigger_select_q[5:4]) == chan_of(pattern_trigger_select_q[7:6]);
  assign shared_low = chan_of(pattern_trigger_select_q[1:0]) == chan_of(pattern_trigger_select_q[3:2]);

  // Read mux, evaluated in setup and registered for the access phase
  always_comb
  begin
    rd_d = '0;
    hit_d = 1'b1;
    if (at(paddr, IDX_MODE))
    begin
      rd_d[REG_W-1:0] = {MODE_RSVD, pattern_output_mode_q};
    end
    else if (at(paddr, IDX_TRIG_SEL))
    begin
      rd_d[REG_W-1:0] = pattern_trigger_select_q;
    end
    else if (at(paddr, IDX_EN_HIGH))
    begin
      rd_d[REG_W-1:0] = next_data_enable_high_q;
    end
    else if (at(paddr, IDX_EN_LOW))
    begin
      rd_d[REG_W-1:0] = next_data_enable_low_q;
    end
    else if (at(paddr, IDX_ND_HIGH_LO))
    begin
      rd_d[REG_W-1:0] = shared_high ? next_data_q[15:8] : {next_data_q[15:12], NIB_ONES};
    end
    else if (at(paddr, IDX_ND_HIGH_HI))
    begin
      rd_d[REG_W-1:0] = shared_high ? BYTE_ONES : {NIB_ONES, next_data_q[11:8]};
    end
    else if (at(paddr, IDX_ND_LOW_LO))
    begin
      rd_d[REG_W-1:0] = shared_low ? next_data_q[7:0] : {next_data_q[7:4], NIB_ONES};
    end
    else if (at(paddr, IDX_ND_LOW_HI))
    begin
      rd_d[REG_W-1:0] = shared_low ? BYTE_ONES : {NIB_ONES, next_data_q[3:0]};
    end
    else
    begin
      hit_d = 1'b0;
    end
  end

  // Answer one cycle after setup; all outputs come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else if (setup)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !hit_d;
      prdata_q <= (pwrite || !hit_d) ? '0 : rd_d;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Mode register, upper bits read as ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pattern_output_mode_q <= MODE_RST;
    end
    else if (wr_en && at(paddr, IDX_MODE))
    begin
      pattern_output_mode_q <= pwdata[3:0];
    end
  end

  // Trigger select register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pattern_trigger_select_q <= TRIG_SEL_RST;
    end
    else if (wr_en && at(paddr, IDX_TRIG_SEL))
    begin
      pattern_trigger_select_q <= pwdata[REG_W-1:0];
    end
  end

  // Enable registers, all lines off after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_data_enable_high_q <= EN_RST;
      next_data_enable_low_q <= EN_RST;
    end
    else
    begin
      if (wr_en && at(paddr, IDX_EN_HIGH))
      begin
        next_data_enable_high_q <= pwdata[REG_W-1:0];
      end
      if (wr_en && at(paddr, IDX_EN_LOW))
      begin
        next_data_enable_low_q <= pwdata[REG_W-1:0];
      end
    end
  end

  // Next data; layout follows whether paired groups share a trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_data_q <= ND_RST;
    end
    else
    begin
      if (wr_en && at(paddr, IDX_ND_HIGH_LO))
      begin
        next_data_q[15:12] <= pwdata[7:4];
        if (shared_high)
        begin
          next_data_q[11:8] <= pwdata[3:0];
        end
      end
      if (wr_en && at(paddr, IDX_ND_HIGH_HI) && !shared_high)
      begin
        next_data_q[11:8] <= pwdata[3:0];
      end
      if (wr_en && at(paddr, IDX_ND_LOW_LO))
      begin
        next_data_q[7:4] <= pwdata[7:4];
        if (shared_low)
        begin
          next_data_q[3:0] <= pwdata[3:0];
        end
      end
      if (wr_en && at(paddr, IDX_ND_LOW_HI) && !shared_low)
      begin
        next_data_q[3:0] <= pwdata[3:0];
      end
    end
  end

  // One slice per group; the slice owns the output flops
  assign line_en = {next_data_enable_high_q, next_data_enable_low_q};
  for (genvar g = 0; g < GROUPS; g++)
  begin : grp
    pattern_group u_group (
      .pclk(pclk),
      .presetn(presetn),
      .sel(pattern_trigger_select_q[g*SEL_W +: SEL_W]),
      .nonoverlap(pattern_output_mode_q[g]),
      .line_en(line_en[g*GROUP_W +: GROUP_W]),
      .next_data(next_data_q[g*GROUP_W +: GROUP_W]),
      .cm_a(cm_a),
      .cm_b(cm_b),
      .lines_q(lines[g*GROUP_W +: GROUP_W])
    );
  end

  assign port_a_pins = lines[7:0];
  assign port_b_pins = lines[15:8];
  assign port_a_oe = next_data_enable_low_q;
  assign port_b_oe = next_data_enable_high_q;

  // Bus phase sequences
  sequence s_setup_at(logic [19:0] idx);
    psel && !penable && !pwrite && at(paddr, idx);
  endsequence

  sequence s_access_done;
    psel && penable && pready_q;
  endsequence

  // Mode reserved bits read as ones
  a_mode_rsvd_ones: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_at(IDX_MODE) |=> (prdata_q[7:4] == MODE_RSVD))
    else $error("mode reserved bits not ones");

  // Shared trigger: upper next-data address reads all ones
  a_shared_upper_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup_at(IDX_ND_HIGH_HI) and shared_high) |=> (prdata_q[REG_W-1:0] == BYTE_ONES))
    else $error("shared upper address not all ones");

  // Split trigger: lower address low nibble reads ones, high nibble is group 3
  a_split_lower_read: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup_at(IDX_ND_HIGH_LO) and !shared_high) |=>
      (prdata_q[REG_W-1:0] == {next_data_q[15:12], NIB_ONES}))
    else $error("split lower address layout wrong");

  // Enable write lands at access completion
  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && at(paddr, IDX_EN_HIGH))) |=>
      (next_data_enable_high_q == $past(pwdata[REG_W-1:0])))
    else $error("enable write lost");

  // Every access answers in the cycle after setup
  a_answer_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready_q ##1 !pready_q)
    else $error("pready timing wrong");

  // Low enable write lands at access completion
  a_enable_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && at(paddr, IDX_EN_LOW))) |=>
      (next_data_enable_low_q == $past(pwdata[REG_W-1:0])))
    else $error("low enable write lost");

  // Trigger select write lands at access completion
  a_trig_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && at(paddr, IDX_TRIG_SEL))) |=>
      (pattern_trigger_select_q == $past(pwdata[REG_W-1:0])))
    else $error("trigger select write lost");

  // Shared trigger: a write to the upper next-data address must not land
  a_shared_upper_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && at(paddr, IDX_ND_HIGH_HI) && shared_high)) |=> $stable(next_data_q))
    else $error("shared upper address write landed");

  // Split trigger: upper address high nibble reads ones, low nibble is group 2
  a_split_upper_read: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup_at(IDX_ND_HIGH_HI) and !shared_high) |=>
      (prdata_q[REG_W-1:0] == {NIB_ONES, next_data_q[11:8]}))
    else $error("split upper address layout wrong");

  // Unmapped address is refused with an error and zero data
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit_d) |=> (pslverr_q && prdata_q == '0))
    else $error("unmapped access not refused");

endmodule

// ==== timer_match_model.sv ====
// Model of the 16-bit timer side: compare match A and B pulses per channel.
// Assumes the bench calls fire from its main sequence, one pulse at a time.
`timescale 1ns/1ps
module timer_match_model
  import pattern_output_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Compare match pulses
  output logic [CHANNELS-1:0] cm_a,
  output logic [CHANNELS-1:0] cm_b
);
  // Quiet until a match is requested
  initial
  begin
    cm_a = '0;
    cm_b = '0;
  end

  // One-cycle pulse, as a real timer gives one per match; never left high
  task automatic fire(input int ch, input logic on_b);
    @(posedge pclk);
    if (on_b)
    begin
      cm_b[ch] <= 1'b1;
    end
    else
    begin
      cm_a[ch] <= 1'b1;
    end
    @(posedge pclk);
    cm_a <= '0;
    cm_b <= '0;
  endtask
endmodule

// ==== pulse_pattern_output_control_tb_top.sv ====
// Self-checking bench for the pattern output control block.
// Assumes the timer model beside it and an APB master made of tasks here.
`timescale 1ns/1ps
module pulse_pattern_output_control_tb_top
  import pattern_output_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [CHANNELS-1:0] cm_a;
  logic [CHANNELS-1:0] cm_b;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [7:0] pao;
  logic [7:0] pbo;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  logic [15:0] exp_p;
  logic [15:0] nd;
  logic [15:0] en;

  // Clock at 10 MHz
  always #50 pclk = ~pclk;

  timer_match_model tmr (.pclk(pclk), .cm_a(cm_a), .cm_b(cm_b));

  pattern_output_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cm_a(cm_a), .cm_b(cm_b), .port_a_pins(pa), .port_b_pins(pb),
    .port_a_oe(pao), .port_b_oe(pbo));

  // Verdict in one place
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bit 32 carries the error response so a wrong pslverr is caught too
  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [15:0] exp);
    #1;
    total_checks++;
    if ({pb, pa} !== exp)
    begin
      err_count++;
      $display("BAD pins t=%0t got=%h exp=%h", $time, {pb, pa}, exp);
    end
  endtask

  // APB transfer; waits for pready under a bound, the hang limit
  task automatic apb(input logic wr, input logic [19:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, WORD_PAD};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      results();
    end
  endtask

  task automatic rdchk(input logic [19:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk_reg({er, rd}, {1'b0, 24'h000000, exp});
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rdchk(IDX_MODE, 8'hF0);
    rdchk(IDX_TRIG_SEL, 8'h00);
    rdchk(IDX_EN_HIGH, 8'h00);
    rdchk(IDX_EN_LOW, 8'h00);
    rdchk(IDX_ND_HIGH_HI, 8'hFF);
    apb(1'b1, IDX_ND_HIGH_HI, 8'h5A);
    rdchk(IDX_ND_HIGH_LO, 8'h00);
    rdchk(IDX_ND_LOW_HI, 8'hFF);
    chk_pin(16'h0000);
    chk_reg({pbo, pao}, 32'h0);
    $display("test reset done");
    // Every select code against the channel it picks; wrong channel first
    apb(1'b1, IDX_EN_HIGH, 8'hFF);
    apb(1'b1, IDX_EN_LOW, 8'hFF);
    rdchk(IDX_EN_LOW, 8'hFF);
    chk_reg({pbo, pao}, 32'hFFFF);
    exp_p = 16'h0000;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, IDX_TRIG_SEL, {4{c[1:0]}});
      nd = 16'h5AC3 ^ {4{c[3:0] + 4'h1}};
      apb(1'b1, IDX_ND_HIGH_LO, nd[15:8]);
      apb(1'b1, IDX_ND_LOW_LO, nd[7:0]);
      tmr.fire((c == 0) ? 1 : 0, 1'b0);
      chk_pin(exp_p);
      tmr.fire((c > 1) ? 2 : c, 1'b0);
      exp_p = nd;
      chk_pin(exp_p);
    end
    $display("test select done");
    // Disabled lines keep their level
    en = 16'h0FF0;
    apb(1'b1, IDX_EN_HIGH, en[15:8]);
    apb(1'b1, IDX_EN_LOW, en[7:0]);
    apb(1'b1, IDX_TRIG_SEL, 8'h00);
    nd = ~exp_p;
    apb(1'b1, IDX_ND_HIGH_LO, nd[15:8]);
    apb(1'b1, IDX_ND_LOW_LO, nd[7:0]);
    tmr.fire(0, 1'b0);
    exp_p = (exp_p & ~en) | (nd & en);
    chk_pin(exp_p);
    chk_reg({pbo, pao}, {16'h0000, en});
    $display("test enable done");
    // Split triggers for groups 2 and 3
    apb(1'b1, IDX_EN_HIGH, 8'hFF);
    apb(1'b1, IDX_TRIG_SEL, 8'h40);
    apb(1'b1, IDX_ND_HIGH_LO, 8'hA5);
    apb(1'b1, IDX_ND_HIGH_HI, 8'h3C);
    rdchk(IDX_ND_HIGH_LO, 8'hAF);
    rdchk(IDX_ND_HIGH_HI, 8'hFC);
    tmr.fire(1, 1'b0);
    chk_pin({4'hA, exp_p[11:0]});
    tmr.fire(0, 1'b0);
    #1;
    chk_reg({24'h0, pb}, 32'hAC);
    $display("test split done");
    // Group 0 non-overlap, group 1 normal: match B clears differing lines only in group 0
    apb(1'b1, IDX_MODE, 8'h01);
    rdchk(IDX_MODE, 8'hF1);
    apb(1'b1, IDX_EN_LOW, 8'hFF);
    apb(1'b1, IDX_TRIG_SEL, 8'h00);
    apb(1'b1, IDX_ND_LOW_LO, 8'h96);
    tmr.fire(0, 1'b0);
    apb(1'b1, IDX_ND_LOW_LO, 8'h53);
    tmr.fire(0, 1'b1);
    chk_pin({8'hAC, 8'h92});
    tmr.fire(0, 1'b0);
    chk_pin({8'hAC, 8'h53});
    $display("test nonoverlap done");
    // Unmapped address answers with an error and zero data
    apb(1'b0, 20'hFFFA8, 8'h00);
    chk_reg({er, rd}, {1'b1, 32'h0});
    $display("test unmapped done");
    results();
  end
endmodule
